// ==== design/flag_cell.sv ====
// One sticky event flag with host clear deferred during sleep.
`timescale 1ns/1ps
module flag_cell
   import radio_event_pkg::*;
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic sys_rst,
   // Event, clear and sleep control.
   input  wire logic set_event,
   input  wire logic host_clear,
   input  wire logic asleep,
   input  wire logic wake_done,
   // Flag.
   output logic      flag_q
);
   logic flag_d;
   logic pend_q;
   logic pend_d;

   // Set wins over any clear; a clear in sleep waits for clock stabilisation.
   always_comb begin
      pend_d = pend_q;
      flag_d = flag_q;
      if (host_clear && asleep) pend_d = 1'b1;
      if (host_clear && !asleep) flag_d = 1'b0;
      if (pend_q && wake_done) begin
         flag_d = 1'b0;
         pend_d = 1'b0;
      end
      if (set_event) flag_d = 1'b1;
   end

   // Registers the flag and the pending clear.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         pend_q <= pend_d;
      end
   end
endmodule

// ==== design/length_error_check.sv ====
// Length legality checker shared by transmit and receive paths.
`timescale 1ns/1ps
module length_error_check
   import radio_event_pkg::*;
(
   // Packet settings.
   input  wire logic [1:0]  format,
   input  wire logic [1:0]  extension,
   input  wire logic [1:0]  crc_kind,
   input  wire logic        is_rx,
   // Length under test and verdict.
   input  wire logic [15:0] length,
   output logic             bad
);
   // Flags an illegal length for the selected format, extension and CRC kind.
   always_comb begin
      bad = 1'b0;
      case (format)
         FMT_A: begin
            if (extension == EXT_NONE) bad = length < LEN_8;
            else if (extension == EXT_TWO) bad = length < LEN_12;
            else bad = length < LEN_16;
         end
         FMT_B: begin
            if (extension == EXT_EIGHT) begin
               bad = (length < LEN_17) || (length == LEN_19) || (length == LEN_20)
                     || (length == LEN_128) || (length == LEN_129);
            end else if (!is_rx) begin
               bad = (length < LEN_10) || (length == LEN_128) || (length == LEN_129);
            end else if (extension == EXT_NONE) begin
               bad = (length < LEN_10) || (length == LEN_128) || (length == LEN_129);
            end
         end
         FMT_C: begin
            if (crc_kind == CRC_8) bad = length == LEN_0;
            else if (crc_kind == CRC_16) bad = length == LEN_1;
            else bad = length == LEN_2;
         end
         default: bad = 1'b0;
      endcase
   end
endmodule

// ==== design/radio_event_flags.sv ====
// Event flags, masks, CRC error flag and interrupt pin with an AXI4-Lite register slave.
`timescale 1ns/1ps
module radio_event_flags
   import radio_event_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // AXI4-Lite write address and data.
   input  wire logic [8:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [8:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Event sources, one-cycle pulses from the packet engine.
   input  wire logic        timer2_event,
   input  wire logic        timer1_event,
   input  wire logic        fifo_error_event,
   input  wire logic        cca_done_event,
   input  wire logic        accept_done_event,
   input  wire logic        tx_done_event,
   input  wire logic        rx_length_valid,
   input  wire logic [15:0] rx_length,
   input  wire logic        crc17_result_valid,
   input  wire logic        crc17_failed,
   // Flags of groups one and two, owned elsewhere, and sleep status.
   input  wire logic [7:0]  group_one_flags,
   input  wire logic [7:0]  group_two_flags,
   input  wire logic        asleep,
   input  wire logic        wake_done,
   // Outputs.
   output logic             rx_length_error,
   output logic             irq_n,
   output logic             irq
);
   logic [7:0]  ridx;
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic        wlane_q, wlane_d;
   logic        have_aw_q, have_aw_d, have_w_q, have_w_d;
   bus_state_t  state_q, state_d;
   logic [31:0] rdata_d;
   logic [1:0]  rresp_d, bresp_d;
   logic [7:0]  mask1_q, mask1_d, mask2_q, mask2_d, mask3_q, mask3_d;
   logic [7:0]  irqen_q, irqen_d;
   logic [7:0]  fmt_q, fmt_d;
   logic [15:0] txlen_q, txlen_d;
   logic        crc17_q, crc17_d;
   logic        rxerr_q, rxerr_d;
   logic        irq_n_q, irq_q;
   logic [2:0]  sts_q, sts_d;
   logic [7:0]  tx_flags;
   logic [7:0]  set_vec;
   logic [7:0]  clr_vec;
   logic        do_write, len_write, tx_bad, rx_bad;
   logic [7:0]  pend_irq;
   logic        awready_q, wready_q, arready_q, bvalid_q, rvalid_q;

   // Read index from the byte address; the two low address bits select nothing.
   assign ridx = {1'b0, s_axi_araddr[8:2]};

   // Length checks for the transmit length register and the received length field.
   length_error_check u_tx_check (
      .format   (fmt_q[FMT_POS +: 2]),
      .extension(fmt_q[EXT_POS +: 2]),
      .crc_kind (fmt_q[CRC_POS +: 2]),
      .is_rx    (1'b0),
      .length   (txlen_d),
      .bad      (tx_bad)
   );
   length_error_check u_rx_check (
      .format   (fmt_q[FMT_POS +: 2]),
      .extension(fmt_q[EXT_POS +: 2]),
      .crc_kind (fmt_q[CRC_POS +: 2]),
      .is_rx    (1'b1),
      .length   (rx_length),
      .bad      (rx_bad)
   );

   // Event vector of the transmit flag register; bit 5 never sets.
   always_comb begin
      set_vec = RST_BYTE;
      set_vec[BIT_TIMER2]    = timer2_event;
      set_vec[BIT_TIMER1]    = timer1_event;
      set_vec[BIT_FIFO_ERR]  = fifo_error_event;
      set_vec[BIT_TXLEN_ERR] = len_write && tx_bad;
      set_vec[BIT_CCA_DONE]  = cca_done_event;
      set_vec[BIT_ACCEPT]    = accept_done_event;
      set_vec[BIT_TX_DONE]   = tx_done_event;
   end

   // A written zero clears the matching flag; ones are ignored.
   always_comb begin
      clr_vec = RST_BYTE;
      if (do_write && awaddr_q == IDX_TX_EVENT_FLAGS && wlane_q) clr_vec = ~wdata_q[7:0];
   end

   // One sticky flag per transmit event bit.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         if (gi == BIT_RESERVED) begin : g_res
            assign tx_flags[gi] = 1'b0;
         end else begin : g_cell
            flag_cell u_cell (
               .clk       (clk),
               .sys_rst   (sys_rst),
               .set_event (set_vec[gi]),
               .host_clear(clr_vec[gi]),
               .asleep    (asleep),
               .wake_done (wake_done),
               .flag_q    (tx_flags[gi])
            );
         end
      end
   endgenerate

   // Bus handshake and register updates.
   assign do_write  = (state_q == BUS_IDLE) && have_aw_q && have_w_q;
   assign len_write = do_write && wlane_q && (awaddr_q == IDX_TX_LENGTH_LOW || awaddr_q == IDX_TX_LENGTH_HIGH);
   always_comb begin
      state_d   = state_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wlane_d   = wlane_q;
      have_aw_d = have_aw_q;
      have_w_d  = have_w_q;
      mask1_d   = mask1_q;
      mask2_d   = mask2_q;
      mask3_d   = mask3_q;
      irqen_d   = irqen_q;
      fmt_d     = fmt_q;
      txlen_d   = txlen_q;
      rdata_d   = s_axi_rdata;
      rresp_d   = s_axi_rresp;
      bresp_d   = s_axi_bresp;
      if (s_axi_awvalid && !have_aw_q && state_q == BUS_IDLE) begin
         awaddr_d  = {1'b0, s_axi_awaddr[8:2]};
         have_aw_d = 1'b1;
      end
      if (s_axi_wvalid && !have_w_q && state_q == BUS_IDLE) begin
         wdata_d  = s_axi_wdata;
         wlane_d  = s_axi_wstrb[0];
         have_w_d = 1'b1;
      end
      case (state_q)
         BUS_IDLE: begin
            if (do_write) begin
               have_aw_d = 1'b0;
               have_w_d  = 1'b0;
               bresp_d   = RESP_OKAY;
               state_d   = BUS_WRSP;
               if (!wlane_q) begin
                  bresp_d = RESP_OKAY;
               end else if (awaddr_q == IDX_MASK_GROUP_ONE) begin
                  mask1_d = wdata_q[7:0];
               end else if (awaddr_q == IDX_MASK_GROUP_TWO) begin
                  mask2_d = wdata_q[7:0];
               end else if (awaddr_q == IDX_MASK_GROUP_THREE) begin
                  mask3_d = wdata_q[7:0];
               end else if (awaddr_q == IDX_FORMAT_CONTROL) begin
                  fmt_d = wdata_q[7:0];
               end else if (awaddr_q == IDX_TX_LENGTH_HIGH) begin
                  txlen_d = {wdata_q[7:0], txlen_q[7:0]};
               end else if (awaddr_q == IDX_TX_LENGTH_LOW) begin
                  txlen_d = {txlen_q[15:8], wdata_q[7:0]};
               end else if (awaddr_q == IDX_TX_EVENT_FLAGS || awaddr_q == IDX_CRC_ERROR_UPPER) begin
                  bresp_d = RESP_OKAY;
               end else if (awaddr_q == IDX_IRQ_STATUS + 8'h01) begin
                  irqen_d = wdata_q[7:0];
               end else begin
                  bresp_d = RESP_SLVERR;
               end
            end else if (s_axi_arvalid) begin
               state_d = BUS_RRSP;
               rresp_d = RESP_OKAY;
               rdata_d = RST_WORD;
               if (ridx == IDX_TX_EVENT_FLAGS) begin
                  rdata_d[7:0] = tx_flags;
               end else if (ridx == IDX_MASK_GROUP_ONE) begin
                  rdata_d[7:0] = mask1_q;
               end else if (ridx == IDX_MASK_GROUP_TWO) begin
                  rdata_d[7:0] = mask2_q;
               end else if (ridx == IDX_MASK_GROUP_THREE) begin
                  rdata_d[7:0] = mask3_q;
               end else if (ridx == IDX_CRC_ERROR_UPPER) begin
                  rdata_d[0] = crc17_q;
               end else if (ridx == IDX_FORMAT_CONTROL) begin
                  rdata_d[7:0] = fmt_q;
               end else if (ridx == IDX_TX_LENGTH_HIGH) begin
                  rdata_d[7:0] = txlen_q[15:8];
               end else if (ridx == IDX_TX_LENGTH_LOW) begin
                  rdata_d[7:0] = txlen_q[7:0];
               end else if (ridx == IDX_IRQ_STATUS) begin
                  rdata_d[2:0] = sts_q;
               end else if (ridx == IDX_IRQ_STATUS + 8'h01) begin
                  rdata_d[2:0] = irqen_q[2:0];
               end else begin
                  rresp_d = RESP_SLVERR;
               end
            end
         end
         BUS_WRSP: if (s_axi_bready) state_d = BUS_IDLE;
         BUS_RRSP: if (s_axi_rready) state_d = BUS_IDLE;
         default: state_d = BUS_IDLE;
      endcase
   end

   // CRC block 17 status, cleared only by a new result; receive length error is high for one cycle per bad length.
   always_comb begin
      crc17_d = crc17_q;
      if (crc17_result_valid) crc17_d = crc17_failed;
      rxerr_d = rx_length_valid && rx_bad;
   end

   // Own interrupt status: bit0 new rx length error, bit1 pin asserted, bit2 crc17 failure; read clears.
   always_comb begin
      sts_d = sts_q;
      if (state_q == BUS_IDLE && !do_write && s_axi_arvalid && ridx == IDX_IRQ_STATUS)
         sts_d = 3'b000;
      if (rxerr_d) sts_d[0] = 1'b1;
      if (|pend_irq) sts_d[1] = 1'b1;
      if (crc17_result_valid && crc17_failed) sts_d[2] = 1'b1;
   end

   // Enabled flags that hold the pin low.
   assign pend_irq = (tx_flags & mask3_q) | (group_one_flags & mask1_q) | (group_two_flags & mask2_q);

   // Registers all state; outputs come straight from flip-flops.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q   <= BUS_IDLE;
         awaddr_q  <= RST_BYTE;
         wdata_q   <= RST_WORD;
         wlane_q   <= 1'b0;
         have_aw_q <= 1'b0;
         have_w_q  <= 1'b0;
         mask1_q   <= RST_BYTE;
         mask2_q   <= RST_BYTE;
         mask3_q   <= RST_BYTE;
         irqen_q   <= RST_BYTE;
         fmt_q     <= RST_BYTE;
         txlen_q   <= 16'h0000;
         crc17_q   <= 1'b0;
         rxerr_q   <= 1'b0;
         sts_q     <= 3'b000;
         irq_n_q   <= 1'b1;
         irq_q     <= 1'b0;
         s_axi_rdata <= RST_WORD;
         s_axi_rresp <= RESP_OKAY;
         s_axi_bresp <= RESP_OKAY;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         arready_q <= 1'b1;
         bvalid_q  <= 1'b0;
         rvalid_q  <= 1'b0;
      end else begin
         state_q   <= state_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wlane_q   <= wlane_d;
         have_aw_q <= have_aw_d;
         have_w_q  <= have_w_d;
         mask1_q   <= mask1_d;
         mask2_q   <= mask2_d;
         mask3_q   <= mask3_d;
         irqen_q   <= irqen_d;
         fmt_q     <= fmt_d;
         txlen_q   <= txlen_d;
         crc17_q   <= crc17_d;
         rxerr_q   <= rxerr_d;
         sts_q     <= sts_d;
         irq_n_q   <= ~(|pend_irq);
         irq_q     <= |(sts_d & irqen_d[2:0]);
         s_axi_rdata <= rdata_d;
         s_axi_rresp <= rresp_d;
         s_axi_bresp <= bresp_d;
         awready_q <= !have_aw_d && state_d == BUS_IDLE;
         wready_q  <= !have_w_d && state_d == BUS_IDLE;
         arready_q <= state_d == BUS_IDLE && !(have_aw_d && have_w_d);
         bvalid_q  <= state_d == BUS_WRSP;
         rvalid_q  <= state_d == BUS_RRSP;
      end
   end

   assign s_axi_awready   = awready_q;
   assign s_axi_wready    = wready_q;
   assign s_axi_bvalid    = bvalid_q;
   assign s_axi_arready   = arready_q;
   assign s_axi_rvalid    = rvalid_q;
   assign rx_length_error = rxerr_q;
   assign irq_n           = irq_n_q;
   assign irq             = irq_q;

   // Checks on the interrupt pin, masks and flags.
   property p_pin_low;
      @(posedge clk) disable iff (sys_rst) (|pend_irq) |=> !irq_n;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin not low with enabled flag");
   property p_pin_high;
      @(posedge clk) disable iff (sys_rst) !(|pend_irq) |=> irq_n;
   endproperty
   a_pin_high: assert property (p_pin_high) else $error("pin low without enabled flag");
   property p_reserved;
      @(posedge clk) disable iff (sys_rst) tx_flags[BIT_RESERVED] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved flag set");
   property p_done_sticks;
      @(posedge clk) disable iff (sys_rst) tx_done_event |=> tx_flags[BIT_TX_DONE];
   endproperty
   a_done_sticks: assert property (p_done_sticks) else $error("tx done flag not set");
   property p_hold;
      @(posedge clk) disable iff (sys_rst) tx_flags[BIT_TIMER1] && !clr_vec[BIT_TIMER1] && !asleep
         && !wake_done |=> tx_flags[BIT_TIMER1];
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped without clear");
   property p_clear;
      @(posedge clk) disable iff (sys_rst) clr_vec[BIT_CCA_DONE] && !asleep && !cca_done_event
         |=> !tx_flags[BIT_CCA_DONE];
   endproperty
   a_clear: assert property (p_clear) else $error("zero write did not clear");
   property p_lenerr;
      @(posedge clk) disable iff (sys_rst) len_write && tx_bad |=> tx_flags[BIT_TXLEN_ERR];
   endproperty
   a_lenerr: assert property (p_lenerr) else $error("tx length error missed");
   property p_rxerr;
      @(posedge clk) disable iff (sys_rst) rx_length_valid && rx_bad |=> rx_length_error;
   endproperty
   a_rxerr: assert property (p_rxerr) else $error("rx length error missed");
   c_irq: cover property (@(posedge clk) disable iff (sys_rst) $fell(irq_n));
   c_write: cover property (@(posedge clk) disable iff (sys_rst) do_write);
   c_sleep: cover property (@(posedge clk) disable iff (sys_rst) asleep && (|clr_vec));
endmodule

// ==== design/radio_event_pkg.sv ====
// Package with register offsets, field positions, reset values and encodings for the event flag block.
package radio_event_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] IDX_TX_EVENT_FLAGS   = 8'h0F;
   localparam logic [7:0] IDX_MASK_GROUP_ONE   = 8'h10;
   localparam logic [7:0] IDX_MASK_GROUP_TWO   = 8'h11;
   localparam logic [7:0] IDX_MASK_GROUP_THREE = 8'h12;
   localparam logic [7:0] IDX_CRC_ERROR_UPPER  = 8'h13;
   localparam logic [7:0] IDX_TX_LENGTH_LOW    = 8'h7B;
   localparam logic [7:0] IDX_TX_LENGTH_HIGH   = 8'h7A;
   localparam logic [7:0] IDX_FORMAT_CONTROL   = 8'h04;
   localparam logic [7:0] IDX_RX_EVENT_FLAGS   = 8'h0E;
   localparam logic [7:0] IDX_IRQ_STATUS       = 8'h40;

   // Bit positions inside the transmit event flag register.
   localparam int BIT_TIMER2    = 7;
   localparam int BIT_TIMER1    = 6;
   localparam int BIT_RESERVED  = 5;
   localparam int BIT_FIFO_ERR  = 4;
   localparam int BIT_TXLEN_ERR = 3;
   localparam int BIT_CCA_DONE  = 2;
   localparam int BIT_ACCEPT    = 1;
   localparam int BIT_TX_DONE   = 0;
   // Bit position of the receive length error inside the receive flag register.
   localparam int BIT_RXLEN_ERR = 3;

   // Reset values.
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Packet format and extension encodings in the format control register.
   localparam logic [1:0] FMT_A    = 2'h0;
   localparam logic [1:0] FMT_B    = 2'h1;
   localparam logic [1:0] FMT_C    = 2'h2;
   localparam logic [1:0] EXT_NONE = 2'h0;
   localparam logic [1:0] EXT_TWO  = 2'h1;
   localparam logic [1:0] EXT_EIGHT = 2'h2;
   localparam logic [1:0] CRC_8    = 2'h0;
   localparam logic [1:0] CRC_16   = 2'h1;
   localparam logic [1:0] CRC_32   = 2'h2;
   localparam int FMT_POS = 0;
   localparam int EXT_POS = 2;
   localparam int CRC_POS = 4;

   // Length thresholds.
   localparam logic [15:0] LEN_8   = 16'h0008;
   localparam logic [15:0] LEN_10  = 16'h000A;
   localparam logic [15:0] LEN_12  = 16'h000C;
   localparam logic [15:0] LEN_16  = 16'h0010;
   localparam logic [15:0] LEN_17  = 16'h0011;
   localparam logic [15:0] LEN_19  = 16'h0013;
   localparam logic [15:0] LEN_20  = 16'h0014;
   localparam logic [15:0] LEN_128 = 16'h0080;
   localparam logic [15:0] LEN_129 = 16'h0081;
   localparam logic [15:0] LEN_0   = 16'h0000;
   localparam logic [15:0] LEN_1   = 16'h0001;
   localparam logic [15:0] LEN_2   = 16'h0002;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Bus slave states.
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRSP = 3'b010,
      BUS_RRSP = 3'b100
   } bus_state_t;

endpackage

// ==== test/axi_host.sv ====
// Host model that reaches the event flag registers over AXI4-Lite.
`timescale 1ns/1ps
module axi_host (
   // Clock.
   input  wire logic        clk,
   // Write channels.
   output logic [8:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   // Read channels.
   output logic [8:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   // The bus is idle at time zero.
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 54'h0;
   end
   // One write; flags are cleared only here and by sys_rst, a write during sleep clearing them after wake_done.
   task automatic wr(input logic [8:0] a, input logic [31:0] v, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      s_axi_wdata <= ~v;
   endtask
   // One read; the answer is taken at the edge where rvalid is seen.
   task automatic rd(input logic [8:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the event flags, masks and interrupt pin.
`timescale 1ns/1ps
module testbench;
   import radio_event_pkg::*;
   localparam logic [8:0] A_FL = {IDX_TX_EVENT_FLAGS[6:0], 2'b00};
   localparam logic [8:0] A_M1 = {IDX_MASK_GROUP_ONE[6:0], 2'b00};
   localparam logic [8:0] A_CRC = {IDX_CRC_ERROR_UPPER[6:0], 2'b00};
   localparam logic [8:0] A_FMT = {IDX_FORMAT_CONTROL[6:0], 2'b00};
   localparam logic [8:0] A_LH = {IDX_TX_LENGTH_HIGH[6:0], 2'b00};
   localparam logic [8:0] A_LL = {IDX_TX_LENGTH_LOW[6:0], 2'b00};
   localparam logic [8:0] A_ST = {IDX_IRQ_STATUS[6:0], 2'b00};
   localparam logic [8:0] A_IE = 9'(A_ST + 9'h004);
   localparam logic [9:0] TX_BAD = 10'h3AB;
   localparam logic [7:0] RX_BAD = 8'h6D;
   logic clk = 1'b0, sys_rst = 1'b1, rx_valid = 1'b0, crc_v = 1'b0, crc_f = 1'b0, asleep = 1'b0, wake = 1'b0;
   logic [5:0] ev = 6'h00;
   logic [15:0] rx_len = 16'h0000;
   logic [7:0] g1 = 8'h00, g2 = 8'h00;
   logic [8:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_err, irq_n, irq;
   int bad_count = 0, n_tests = 0, cyc = 0;
   int lb[8] = '{16, 17, 19, 20, 21, 128, 129, 130};
   logic [7:0] tf[10] = '{8'h02, 8'h12, 8'h12, 8'h22, 8'h22, 8'h01, 8'h01, 8'h01, 8'h05, 8'h09};
   logic [7:0] tl[10] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h00, 8'h09, 8'h0A, 8'h81, 8'h09, 8'h13};
   radio_event_flags dut_u (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .timer2_event(ev[5]), .timer1_event(ev[4]), .fifo_error_event(ev[3]), .cca_done_event(ev[2]),
      .accept_done_event(ev[1]), .tx_done_event(ev[0]), .rx_length_valid(rx_valid), .rx_length(rx_len),
      .crc17_result_valid(crc_v), .crc17_failed(crc_f), .group_one_flags(g1), .group_two_flags(g2),
      .asleep, .wake_done(wake), .rx_length_error(rx_err), .irq_n, .irq);
   axi_host host_u (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [8:0] a, input logic [31:0] e);
      host_u.rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
   endtask
   task automatic wrc(input logic [8:0] a, input logic [31:0] v);
      host_u.wr(a, v, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
   endtask
   task automatic pulse(input logic [5:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 6'h00;
   endtask
   task automatic irqc(input logic e);
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, irq_n}, {31'h0, e});
   endtask
   task automatic irqh(input logic e);
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, irq}, {31'h0, e});
   endtask
   task automatic txc(input logic [7:0] f, input logic [7:0] n, input logic e);
      wrc(A_FMT, {24'h0, f});
      wrc(A_LL, {24'h0, n});
      rdc(A_FL, {28'h0, e, 3'h0});
      wrc(A_FL, 32'h0);
   endtask
   task automatic rxc(input logic [1:0] f, input logic [1:0] x, input logic [15:0] n, input logic e);
      wrc(A_FMT, {28'h0, x, f});
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_len <= n;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_len <= ~n;
      #1;
      chk({31'h0, rx_err}, {31'h0, e});
   endtask
   task automatic crcc(input logic f);
      @(posedge clk);
      {crc_v, crc_f} <= {1'b1, f};
      @(posedge clk);
      {crc_v, crc_f} <= 2'h0;
      rdc(A_CRC, {31'h0, f});
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Clock of 4 ns period.
   initial forever #2 clk = ~clk;
   // Cycle ceiling against hangs.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         $display("mismatch at %0t: timeout", $time);
         results;
      end
   end
   // Main sequence of register calls and expected values.
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(A_FL, 32'h0);
      rdc(A_CRC, 32'h0);
      chk({31'h0, irq_n}, 32'h1);
      for (int i = 0; i < 3; i++) begin
         rdc(9'(A_M1 + 4 * i), 32'h0);
         wrc(9'(A_M1 + 4 * i), 32'hA5);
         rdc(9'(A_M1 + 4 * i), 32'hA5);
         wrc(9'(A_M1 + 4 * i), 32'h0);
      end
      pulse(6'h3F);
      rdc(A_FL, 32'hD7);
      irqc(1'b1);
      wrc(A_FL, 32'hFF);
      rdc(A_FL, 32'hD7);
      wrc(A_FL, 32'hFE);
      rdc(A_FL, 32'hD6);
      wrc(9'(A_M1 + 8), 32'h02);
      irqc(1'b0);
      irqc(1'b0);
      wrc(A_FL, 32'hFD);
      irqc(1'b1);
      rdc(A_FL, 32'hD4);
      wrc(A_FL, 32'h0);
      @(posedge clk);
      {g1, g2} <= {8'h01, 8'h80};
      wrc(A_M1, 32'h01);
      irqc(1'b0);
      wrc(A_M1, 32'h0);
      irqc(1'b1);
      wrc(9'(A_M1 + 4), 32'h80);
      irqc(1'b0);
      wrc(9'(A_M1 + 4), 32'h0);
      wrc(9'(A_M1 + 8), 32'h40);
      pulse(6'h10);
      @(posedge clk);
      asleep <= 1'b1;
      wrc(A_FL, 32'h0);
      rdc(A_FL, 32'h40);
      irqc(1'b0);
      @(posedge clk);
      asleep <= 1'b0;
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      rdc(A_FL, 32'h0);
      irqc(1'b1);
      for (int e = 0; e < 3; e++) begin
         rxc(FMT_A, 2'(e), 16'(7 + 4 * e), 1'b1);
         rxc(FMT_A, 2'(e), 16'(8 + 4 * e), 1'b0);
      end
      for (int i = 0; i < 8; i++) rxc(FMT_B, EXT_EIGHT, 16'(lb[i]), RX_BAD[i]);
      crcc(1'b1);
      crcc(1'b0);
      rxc(FMT_B, EXT_NONE, 16'h0009, 1'b1);
      rxc(FMT_C, EXT_NONE, 16'h0000, 1'b1);
      rxc(FMT_B, EXT_TWO, 16'h0009, 1'b0);
      for (int i = 0; i < 10; i++) txc(tf[i], tl[i], TX_BAD[i]);
      wrc(A_LH, 32'h01);
      rdc(A_FL, 32'h0);
      rdc(A_LH, 32'h01);
      wrc(A_LH, 32'h0);
      rdc(A_FL, 32'h08);
      wrc(A_FL, 32'h0);
      wrc(A_IE, 32'h04);
      rdc(A_IE, 32'h04);
      irqh(1'b1);
      rdc(A_ST, 32'h07);
      irqh(1'b0);
      rdc(A_ST, 32'h00);
      host_u.rd(9'h000, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      host_u.wr(9'h000, 32'h1, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      results;
   end
endmodule
